// file: design/fiec_top.sv
// Flash erase/write controller: unlock guard, page buffer, timed
// erase and write launch. Assumes an Avalon-MM master on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "fiec_defines.svh"

// Function
// - Unlock accepted only with unlock mode code.
// - Trigger starts a bounded unlock timer.
// - Timer expiry clears trigger by hardware.
// - Matching pattern sets program enable flag.
// - Wrong pattern leaves erase/write disabled.
// - Software clearing enable disables at once.
// - No erase or write without enable.
// - Word0 high writes tag address, then increment.
// - Tag address holds at page last word.
// - Only tagged addresses are erased.
// - Buffer holds 32 words of one page.
// - Buffer address advances after each load below the last word.
// - Buffer address stops at last word.
// - Erase mode launch erases, clears start.
// - Write mode launch programs, clears start.
// - CPU stalled while operation runs.
// - Start-high time follows time select.
// - High byte write loads word, bumps address.
// - Erase 3.2/3.7 ms, write 2.2/3.0 ms.
// - Buffer clear bit self-clears when done.
module fiec_top #(
  parameter int unsigned ER0_CYC = `FIEC_T_ER0_US * `FIEC_CLK_MHZ,
  parameter int unsigned WR0_CYC = `FIEC_T_WR0_US * `FIEC_CLK_MHZ,
  parameter int unsigned ER1_CYC = `FIEC_T_ER1_US * `FIEC_CLK_MHZ,
  parameter int unsigned WR1_CYC = `FIEC_T_WR1_US * `FIEC_CLK_MHZ,
  parameter int unsigned UNLOCK_CYC = `FIEC_UNLOCK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic cpu_stall_q,
  output logic fl_erase_q,
  output logic fl_prog_q,
  output logic [7:0] fl_page_q,
  output logic [31:0] fl_mask_q,
  output logic fl_wstb_q,
  output logic [4:0] fl_widx_q,
  output logic [15:0] fl_wdata_q
);

  fiec_pkg::fiec_state_t st_q;
  logic wait_q;
  logic [31:0] rdat_q;
  logic [2:0] mode_q;
  logic trig_q;
  logic start_q;
  logic pen_q;
  logic tsel_q;
  logic clr_q;
  logic [12:0] adr_q;
  logic [7:0] dat_q [0:7];
  logic [15:0] buf_q [0:31];
  logic [31:0] tag_q;
  logic [31:0] cnt_q;
  logic str_q;
  logic [4:0] sidx_q;
  logic req;
  logic acc;
  logic wr;
  logic [7:0] wb;
  logic [2:0] wmode;
  logic ld_word;
  logic ulk_go;
  logic op_go;
  logic ulk_end;
  logic op_end;
  logic busy;
  logic pat_ok;
  logic [7:0] rmux;

  // Operation length in cycles for the selected kind and timing.
  function automatic logic [31:0] op_len(input logic erase,
                                         input logic tsel);
    if (erase)
    begin
      op_len = tsel ? ER1_CYC : ER0_CYC;
    end
    else
    begin
      op_len = tsel ? WR1_CYC : WR0_CYC;
    end
  endfunction

  assign req = avs_read | avs_write;
  assign acc = req & ~wait_q;
  assign wr = acc & avs_write & avs_byteenable[0];
  assign wb = avs_writedata[7:0];
  assign wmode = wb[`FIEC_F_MODE];
  assign busy = (st_q == fiec_pkg::fiec_st_erase) ||
                (st_q == fiec_pkg::fiec_st_prog);
  assign ulk_end = (st_q == fiec_pkg::fiec_st_unlock) &&
                   (cnt_q == 32'h0000_0000);
  assign op_end = busy && (cnt_q == 32'h0000_0000);
  // Unlock mode gate
  // mode must be unlock code
  assign ulk_go = wr && (avs_address == `FIEC_A_CTRL0) &&
                  wb[`FIEC_B_TRIG] && (wmode == `FIEC_M_UNLOCK) &&
                  (st_q == fiec_pkg::fiec_st_idle);
  // Launch refused unless enabled
  // enable flag gates launch
  assign op_go = wr && (avs_address == `FIEC_A_CTRL0) &&
                 wb[`FIEC_B_START] && pen_q && !ulk_go &&
                 (st_q == fiec_pkg::fiec_st_idle) &&
                 (wmode == `FIEC_M_WRITE || wmode == `FIEC_M_ERASE);
  assign ld_word = wr && (avs_address == `FIEC_A_D0H);
  assign pat_ok = dat_q[2] == `FIEC_PAT_D1L &&
                  dat_q[4] == `FIEC_PAT_D2L &&
                  dat_q[6] == `FIEC_PAT_D3L &&
                  dat_q[3] == `FIEC_PAT_D1H &&
                  dat_q[5] == `FIEC_PAT_D2H &&
                  dat_q[7] == `FIEC_PAT_D3H;

  always_comb
  begin
    rmux = 8'h00;
    unique case (avs_address)
      `FIEC_A_CTRL0: rmux = {pen_q, mode_q, trig_q, start_q, 2'b00};
      `FIEC_A_CTRL2: rmux = {6'h00, tsel_q, clr_q};
      `FIEC_A_ADRL: rmux = adr_q[7:0];
      `FIEC_A_ADRH: rmux = {3'h0, adr_q[12:8]};
      default:
      begin
        if (avs_address >= `FIEC_A_D0L && avs_address <= `FIEC_A_D3H)
        begin
          rmux = dat_q[3'(avs_address[5:2] - 4'h4)];
        end
      end
    endcase
  end

  // One wait cycle per access; held high while the array is busy,
  // which is also how the CPU bus is frozen.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wait_q <= 1'b1;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= ~(req & wait_q & ~busy);
      if (req && wait_q)
      begin
        rdat_q <= {24'h00_0000, rmux};
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mode_q <= `FIEC_M_WRITE;
      tsel_q <= 1'b0;
      clr_q <= 1'b0;
    end
    else
    begin
      if (wr && avs_address == `FIEC_A_CTRL0)
      begin
        mode_q <= wmode;
      end
      if (wr && avs_address == `FIEC_A_CTRL2)
      begin
        tsel_q <= wb[`FIEC_B_TSEL];
      end
      if (wr && avs_address == `FIEC_A_CTRL2 && wb[`FIEC_B_CLR])
      begin
        clr_q <= 1'b1;
      end
      else if (clr_q)
      begin
        clr_q <= 1'b0;
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pen_q <= 1'b0;
    end
    else if (ulk_end && pat_ok)
    begin
      pen_q <= 1'b1;
    end
    else if (wr && avs_address == `FIEC_A_CTRL0 && !wb[`FIEC_B_PEN])
    begin
      pen_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q <= fiec_pkg::fiec_st_idle;
      cnt_q <= 32'h0000_0000;
      trig_q <= 1'b0;
      start_q <= 1'b0;
      fl_erase_q <= 1'b0;
      fl_prog_q <= 1'b0;
      fl_page_q <= 8'h00;
      fl_mask_q <= 32'h0000_0000;
      cpu_stall_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        fiec_pkg::fiec_st_idle:
        begin
          if (ulk_go)
          begin
            st_q <= fiec_pkg::fiec_st_unlock;
            trig_q <= 1'b1;
            cnt_q <= UNLOCK_CYC - 32'h1;
          end
          else if (op_go)
          begin
            st_q <= (wmode == `FIEC_M_ERASE) ?
                    fiec_pkg::fiec_st_erase : fiec_pkg::fiec_st_prog;
            start_q <= 1'b1;
            cnt_q <= op_len(wmode == `FIEC_M_ERASE, tsel_q) - 32'h1;
            fl_erase_q <= (wmode == `FIEC_M_ERASE);
            fl_prog_q <= (wmode == `FIEC_M_WRITE);
            fl_page_q <= adr_q[12:5];
            fl_mask_q <= tag_q;
            cpu_stall_q <= 1'b1;
          end
        end
        fiec_pkg::fiec_st_unlock:
        begin
          if (cnt_q == 32'h0000_0000)
          begin
            st_q <= fiec_pkg::fiec_st_idle;
            trig_q <= 1'b0;
          end
          else
          begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        fiec_pkg::fiec_st_erase, fiec_pkg::fiec_st_prog:
        begin
          if (cnt_q == 32'h0000_0000)
          begin
            st_q <= fiec_pkg::fiec_st_idle;
            start_q <= 1'b0;
            fl_erase_q <= 1'b0;
            fl_prog_q <= 1'b0;
            cpu_stall_q <= 1'b0;
          end
          else
          begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
      endcase
    end
  end

  // Address register and tag mask share the load path.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      adr_q <= 13'h0000;
      tag_q <= 32'h0000_0000;
      for (int i = 0; i < 8; i++)
      begin
        dat_q[i] <= 8'h00;
      end
    end
    else
    begin
      if (wr && avs_address >= `FIEC_A_D0L &&
          avs_address <= `FIEC_A_D3H)
      begin
        dat_q[3'(avs_address[5:2] - 4'h4)] <= wb;
      end
      if (wr && avs_address == `FIEC_A_ADRL)
      begin
        adr_q[7:0] <= wb;
      end
      if (wr && avs_address == `FIEC_A_ADRH)
      begin
        adr_q[12:8] <= wb[4:0];
      end
      if (clr_q)
      begin
        tag_q <= 32'h0000_0000;
      end
      if (ld_word)
      begin
        tag_q[adr_q[4:0]] <= 1'b1;
        if (adr_q[4:0] != `FIEC_LAST)
        begin
          adr_q <= adr_q + 13'h0001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (ld_word)
    begin
      buf_q[adr_q[4:0]] <= {wb, dat_q[0]};
    end
  end

  // Tagged words stream to the array at the start of a write.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      str_q <= 1'b0;
      sidx_q <= 5'h00;
      fl_wstb_q <= 1'b0;
      fl_widx_q <= 5'h00;
      fl_wdata_q <= 16'h0000;
    end
    else if (op_go && wmode == `FIEC_M_WRITE)
    begin
      str_q <= 1'b1;
      sidx_q <= 5'h00;
      fl_wstb_q <= 1'b0;
    end
    else if (str_q)
    begin
      fl_wstb_q <= tag_q[sidx_q];
      fl_widx_q <= sidx_q;
      fl_wdata_q <= buf_q[sidx_q];
      str_q <= (sidx_q != `FIEC_LAST);
      sidx_q <= sidx_q + 5'h01;
    end
    else
    begin
      fl_wstb_q <= 1'b0;
    end
  end

  assign avs_readdata = rdat_q;
  assign avs_waitrequest = wait_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_load_mid;
    ld_word && adr_q[4:0] != `FIEC_LAST;
  endsequence
  sequence s_load_last;
    ld_word && adr_q[4:0] == `FIEC_LAST;
  endsequence

  trig_timeout_a: assert property (ulk_end |=> !trig_q)
    else $error("trigger not cleared at timeout");
  pattern_set_a: assert property (ulk_end && pat_ok |=> pen_q)
    else $error("enable not set on pattern match");
  bad_pattern_a: assert property
    (ulk_end && !pat_ok && !pen_q |=> !pen_q)
    else $error("enable set on wrong pattern");
  sw_disable_a: assert property
    (wr && avs_address == `FIEC_A_CTRL0 && !wb[`FIEC_B_PEN] &&
     !ulk_end |=> !pen_q)
    else $error("enable not cleared by software");
  refuse_op_a: assert property
    (!pen_q && st_q == fiec_pkg::fiec_st_idle && !ulk_go
     |=> st_q == fiec_pkg::fiec_st_idle)
    else $error("operation launched while disabled");
  addr_incr_a: assert property
    (s_load_mid |=> adr_q == $past(adr_q) + 13'h0001)
    else $error("buffer address did not advance");
  addr_hold_a: assert property
    (s_load_last |=> adr_q == $past(adr_q))
    else $error("buffer address passed page end");
  cpu_stall_a: assert property
    (cpu_stall_q == busy)
    else $error("stall does not match operation");
  op_length_a: assert property
    (op_go |=> cnt_q == op_len(fl_erase_q, tsel_q) - 32'h1)
    else $error("operation length wrong for selection");
  start_end_a: assert property (op_end |=> !start_q && !busy)
    else $error("start bit not cleared at end");
  buf_clear_a: assert property
    (clr_q && !ld_word |=> tag_q == 32'h0000_0000 ##0 !clr_q)
    else $error("buffer clear did not complete");

endmodule
`default_nettype wire

// file: shared/fiec_defines.svh
// Register map, field positions, codes and timing figures of the
// flash erase/write controller; included by the design and bench.
`ifndef FIEC_DEFINES_SVH
`define FIEC_DEFINES_SVH
`define FIEC_A_CTRL0 6'h00
`define FIEC_A_CTRL2 6'h04
`define FIEC_A_ADRL 6'h08
`define FIEC_A_ADRH 6'h0C
`define FIEC_A_D0L 6'h10
`define FIEC_A_D0H 6'h14
`define FIEC_A_D3H 6'h2C
`define FIEC_B_PEN 7
`define FIEC_F_MODE 6:4
`define FIEC_B_TRIG 3
`define FIEC_B_START 2
`define FIEC_B_TSEL 1
`define FIEC_B_CLR 0
`define FIEC_M_WRITE 3'h0
`define FIEC_M_ERASE 3'h1
`define FIEC_M_UNLOCK 3'h6
`define FIEC_PAT_D1L 8'h00
`define FIEC_PAT_D2L 8'h0D
`define FIEC_PAT_D3L 8'hC3
`define FIEC_PAT_D1H 8'h04
`define FIEC_PAT_D2H 8'h09
`define FIEC_PAT_D3H 8'h40
`define FIEC_LAST 5'h1F
`define FIEC_T_ER0_US 3200
`define FIEC_T_WR0_US 2200
`define FIEC_T_ER1_US 3700
`define FIEC_T_WR1_US 3000
`define FIEC_CLK_MHZ 25
`define FIEC_UNLOCK_CYC 1024
`endif

// file: shared/fiec_pkg.sv
// Types shared by the flash erase/write controller and its bench.
// Assumes the defines header supplies all numeric constants.
`default_nettype none
package fiec_pkg;
  typedef enum logic [1:0]
  {
    fiec_st_idle,
    fiec_st_unlock,
    fiec_st_erase,
    fiec_st_prog
  } fiec_state_t;
endpackage
`default_nettype wire

// file: tb/fiec_flash_model.sv
// Behavioural page store standing in for the program flash array.
// Assumes the controller's fl_* outputs are its only stimulus.
`timescale 1ns/1ps
`default_nettype none
module fiec_flash_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic fl_erase_q,
  input wire logic fl_prog_q,
  input wire logic [7:0] fl_page_q,
  input wire logic [31:0] fl_mask_q,
  input wire logic fl_wstb_q,
  input wire logic [4:0] fl_widx_q,
  input wire logic [15:0] fl_wdata_q
);
  // Cells start non-blank so that an erase shows in the cell values.
  logic [15:0] mem [0:8191];
  int wr_cnt = 0;
  int stray_cnt = 0;
  initial
  begin
    for (int i = 0; i < 8192; i++)
      mem[i] = 16'h5A5A;
  end
  always @(posedge sys_clk)
  begin
    if (rst_n && fl_erase_q)
      for (int i = 0; i < 32; i++)
        if (fl_mask_q[i])
          mem[{fl_page_q, i[4:0]}] = 16'h0000;
  end
  always @(posedge sys_clk)
  begin
    if (rst_n && fl_wstb_q)
    begin
      if (!fl_prog_q)
        stray_cnt++;
      mem[{fl_page_q, fl_widx_q}] = fl_wdata_q;
      wr_cnt++;
    end
  end
endmodule
`default_nettype wire

// file: tb/flash_iap_erase_write_ctrl_tb.sv
// Self-checking bench: unlock, buffer load, write and erase runs.
// Assumes the controller answers Avalon-MM and feeds a flash model.
`timescale 1ns/1ps
`default_nettype none
`include "fiec_defines.svh"
module flash_iap_erase_write_ctrl_tb;
  localparam int WR0 = 80;
  localparam int ER1 = 120;
  localparam int UNL = 64;
  localparam int ER0 = 100;
  localparam int WR1 = 90;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, cpu_stall_q, fl_erase_q, fl_prog_q, fl_wstb_q;
  logic [7:0] fl_page_q;
  logic [31:0] fl_mask_q;
  logic [4:0] fl_widx_q;
  logic [15:0] fl_wdata_q;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h0000E55C;
  logic [15:0] exp_buf [0:31];
  logic [7:0] rd;

  always #20 sys_clk = ~sys_clk;

  fiec_top #(.ER0_CYC(ER0), .WR0_CYC(WR0), .ER1_CYC(ER1), .WR1_CYC(WR1),
    .UNLOCK_CYC(UNL)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_stall_q(cpu_stall_q),
    .fl_erase_q(fl_erase_q), .fl_prog_q(fl_prog_q),
    .fl_page_q(fl_page_q), .fl_mask_q(fl_mask_q),
    .fl_wstb_q(fl_wstb_q), .fl_widx_q(fl_widx_q),
    .fl_wdata_q(fl_wdata_q));

  fiec_flash_model FL (.sys_clk(sys_clk), .rst_n(rst_n),
    .fl_erase_q(fl_erase_q), .fl_prog_q(fl_prog_q),
    .fl_page_q(fl_page_q), .fl_mask_q(fl_mask_q),
    .fl_wstb_q(fl_wstb_q), .fl_widx_q(fl_widx_q),
    .fl_wdata_q(fl_wdata_q));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // The request is held until waitrequest is sampled low at an edge.
  task automatic bus(input logic wr, input logic [5:0] a,
    input logic [7:0] d, input logic be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= {3'h7, be};
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask

  task automatic rdc(input string what, input logic [5:0] a,
    input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 1'b1);
    chk(what, {24'h0, exp}, avs_readdata);
  endtask

  task automatic op_run(input logic er, input int len,
    input logic [7:0] pg);
    int n;
    logic st;
    n = 0;
    st = 1'b1;
    while ((er ? fl_erase_q : fl_prog_q) !== 1'b1)
      @(posedge sys_clk);
    chk("page", {24'h0, pg}, {24'h0, fl_page_q});
    while ((er ? fl_erase_q : fl_prog_q) === 1'b1)
    begin
      st = st & cpu_stall_q;
      n++;
      @(posedge sys_clk);
    end
    chk("op length", len, n);
    chk("stall", 32'h1, {31'h0, st});
  endtask

  task automatic unlock(input logic good);
    wr(`FIEC_A_CTRL0, 8'h68);
    rdc("trigger set", `FIEC_A_CTRL0, 8'h68);
    wr(6'h18, `FIEC_PAT_D1L);
    wr(6'h20, `FIEC_PAT_D2L);
    wr(6'h28, `FIEC_PAT_D3L);
    wr(6'h1C, `FIEC_PAT_D1H);
    wr(6'h24, `FIEC_PAT_D2H);
    wr(`FIEC_A_D3H, good ? `FIEC_PAT_D3H : rng[7:0] | 8'h01);
    repeat (UNL + 4) @(posedge sys_clk);
    rdc("unlock result", `FIEC_A_CTRL0, {good, 7'h60});
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 4000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++)
      rdc("reset value", 6'(i * 4), 8'h00);
    wr(`FIEC_A_D3H, 8'hA5);
    bus(1'b1, `FIEC_A_D3H, 8'h5A, 1'b0);
    rdc("data reg", `FIEC_A_D3H, 8'hA5);
    wr(`FIEC_A_CTRL0, 8'h04);
    rdc("start refused", `FIEC_A_CTRL0, 8'h00);
    wr(`FIEC_A_CTRL0, 8'h58);
    rdc("wrong mode", `FIEC_A_CTRL0, 8'h50);
    unlock(1'b0);
    unlock(1'b1);
    wr(`FIEC_A_CTRL2, 8'h01);
    wr(`FIEC_A_ADRL, 8'h20);
    wr(`FIEC_A_ADRH, 8'h00);
    for (int i = 0; i < 33; i++)
    begin
      rng = xs(rng);
      wr(`FIEC_A_D0L, rng[7:0]);
      wr(`FIEC_A_D0H, rng[15:8]);
      exp_buf[i > 31 ? 31 : i] = rng[15:0];
    end
    rdc("addr hold", `FIEC_A_ADRL, 8'h3F);
    wr(`FIEC_A_CTRL0, 8'h84);
    op_run(1'b0, WR0, 8'h01);
    rdc("start cleared", `FIEC_A_CTRL0, 8'h80);
    for (int i = 0; i < 32; i++)
      chk("word", {16'h0, exp_buf[i]}, {16'h0, FL.mem[32 + i]});
    chk("strobes", 32, FL.wr_cnt);
    wr(`FIEC_A_CTRL2, 8'h03);
    rdc("clear done", `FIEC_A_CTRL2, 8'h02);
    wr(`FIEC_A_ADRL, 8'h40);
    repeat (3) wr(`FIEC_A_D0H, 8'h00);
    wr(`FIEC_A_CTRL0, 8'h94);
    op_run(1'b1, ER1, 8'h02);
    rdc("erase done", `FIEC_A_CTRL0, 8'h90);
    for (int i = 0; i < 4; i++)
      chk("erased", i < 3 ? 0 : 32'h5A5A, {16'h0, FL.mem[64 + i]});
    chk("no stray", 0, FL.stray_cnt + FL.wr_cnt - 32);
    wr(`FIEC_A_CTRL2, 8'h03);
    wr(`FIEC_A_ADRL, 8'h20);
    for (int i = 0; i < 2; i++)
    begin
      rng = xs(rng);
      wr(`FIEC_A_D0L, rng[7:0]);
      wr(`FIEC_A_D0H, rng[15:8]);
      exp_buf[i] = rng[15:0];
    end
    wr(`FIEC_A_CTRL0, 8'h84);
    op_run(1'b0, WR1, 8'h01);
    for (int i = 0; i < 3; i++)
      chk("rewrite", {16'h0, exp_buf[i]}, {16'h0, FL.mem[32 + i]});
    chk("rewrite strobes", 34, FL.wr_cnt);
    wr(`FIEC_A_CTRL2, 8'h01);
    wr(`FIEC_A_ADRL, 8'h60);
    wr(`FIEC_A_D0H, 8'h00);
    wr(`FIEC_A_CTRL0, 8'h94);
    op_run(1'b1, ER0, 8'h03);
    chk("erase short", 0, {16'h0, FL.mem[96]});
    chk("untagged", 32'h5A5A, {16'h0, FL.mem[97]});
    wr(`FIEC_A_CTRL0, 8'h00);
    rdc("disable", `FIEC_A_CTRL0, 8'h00);
    wr(`FIEC_A_CTRL0, 8'h84);
    rdc("refused", `FIEC_A_CTRL0, 8'h00);
    chk("no prog", 0, {31'h0, fl_prog_q});
    report_and_stop();
  end
endmodule
`default_nettype wire
